// ==== core/slsu_divider.sv ====
/*
  Sequential unsigned restoring divider, one quotient bit per clock.
  Assumes the divisor is non-zero; the caller screens zero divisors out.
*/
`timescale 1ns/1ps
module slsu_divider
  import slsu_pkg::*;
#(
  parameter int unsigned NUM_W = SLSU_DIV_NUM_W,
  parameter int unsigned DEN_W = SLSU_DIV_DEN_W
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Request
  input  wire logic             start_in,
  input  wire logic [NUM_W-1:0] numer_in,
  input  wire logic [DEN_W-1:0] denom_in,
  // Answer
  output logic                  busy_out,
  output logic                  done_out,
  output logic [NUM_W-1:0]      quot_out,
  output logic [DEN_W-1:0]      rem_out
);

  localparam int unsigned CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] denom;
  logic [CNT_W-1:0] count;

  wire logic [DEN_W:0] shifted = {rem_out, quot_out[NUM_W-1]};
  wire logic           fits    = shifted >= {1'b0, denom};
  wire logic [DEN_W:0] reduced = shifted - {1'b0, denom};

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      denom    <= '0;
      count    <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      quot_out <= '0;
      rem_out  <= '0;
    end else if (start_in && !busy_out) begin
      denom    <= denom_in;
      count    <= CNT_W'(NUM_W);
      busy_out <= 1'b1;
      done_out <= 1'b0;
      quot_out <= numer_in;
      rem_out  <= '0;
    end else if (busy_out) begin
      rem_out  <= fits ? reduced[DEN_W-1:0] : shifted[DEN_W-1:0];
      quot_out <= {quot_out[NUM_W-2:0], fits};
      count    <= count - 1'b1;
      busy_out <= (count != CNT_W'(1));
      done_out <= (count == CNT_W'(1));
    end else begin
      done_out <= 1'b0;
    end
  end

endmodule // slsu_divider

// ==== core/slsu_pkg.sv ====
/*
  Shared constants, types and helper functions for the signed linear scaling unit.
  Assumes a single 10 MHz clock domain and a 32-bit AHB-Lite register bus.
*/
package slsu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int unsigned SLSU_ADDR_W     = 8;
  localparam logic [7:0]  SLSU_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  SLSU_STATUS_OFS = 8'h04;
  localparam logic [7:0]  SLSU_SOURCE_OFS = 8'h08;
  localparam logic [7:0]  SLSU_PARAM0_OFS = 8'h0c;
  localparam logic [7:0]  SLSU_PARAM4_OFS = 8'h1c;
  localparam logic [7:0]  SLSU_RESULT_OFS = 8'h20;
  localparam int unsigned SLSU_PARAM_NUM  = 5;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SLSU_CTRL_FWD_BIT   = 0;
  localparam int unsigned SLSU_CTRL_REV_BIT   = 1;
  localparam int unsigned SLSU_CTRL_SETC_BIT  = 2;
  localparam int unsigned SLSU_CTRL_CLRC_BIT  = 3;
  localparam int unsigned SLSU_STAT_BUSY_BIT  = 0;
  localparam logic [15:0] SLSU_WORD_RESET     = 16'h0000;
  localparam logic [15:0] SLSU_BCD_ZERO       = 16'h0000;

  // Parameter word positions relative to the parameter block base.
  localparam int unsigned SLSU_P_OFFSET = 0;
  localparam int unsigned SLSU_P_RUN    = 1;
  localparam int unsigned SLSU_P_RISE   = 2;
  localparam int unsigned SLSU_P_MAX    = 3;
  localparam int unsigned SLSU_P_MIN    = 4;

  // ----------------------------------------------------------------
  // Arithmetic constants and bus encodings
  // ----------------------------------------------------------------
  localparam logic signed [33:0] SLSU_FWD_LIMIT = 34'sh0000270f;
  localparam int unsigned        SLSU_DIV_NUM_W = 32;
  localparam int unsigned        SLSU_DIV_DEN_W = 16;
  localparam logic               SLSU_HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic negative;
    logic carry;
    logic zero;
    logic error;
  } slsu_flags_s;

  typedef enum logic [1:0] {
    SLSU_IDLE   = 2'b00,
    SLSU_DIVIDE = 2'b01,
    SLSU_FINISH = 2'b11
  } slsu_state_e;

  typedef enum logic {
    SLSU_OP_FWD = 1'b0,
    SLSU_OP_REV = 1'b1
  } slsu_op_e;

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function automatic logic slsu_bcd_valid(input logic [15:0] bcd);
    return (bcd[15:12] < 4'ha) && (bcd[11:8] < 4'ha) && (bcd[7:4] < 4'ha) && (bcd[3:0] < 4'ha);
  endfunction

  function automatic logic [13:0] slsu_bcd_to_bin(input logic [15:0] bcd);
    return 14'(14'(bcd[15:12]) * 14'd1000 + 14'(bcd[11:8]) * 14'd100 + 14'(bcd[7:4]) * 14'd10
               + 14'(bcd[3:0]));
  endfunction

  function automatic logic [15:0] slsu_bin_to_bcd(input logic [13:0] bin);
    logic [29:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14+4*d +: 4] > 4'h4) begin
          sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    return sh[29:14];
  endfunction

endpackage

// ==== core/slsu_scaler.sv ====
/*
  Signed linear scaling unit: forward scaler (signed binary to signed BCD) and
  reverse scaler (signed BCD to clamped signed binary), reached over AHB-Lite.
  Assumes software loads the source and parameter words before it starts an
  operation and leaves them alone while the unit is busy.
*/
// Notes on behaviour
// - Forward result is a BCD magnitude; carry flag set only for a negative result.
// - Forward scaler flags an error when the run-delta word is zero.
// - Forward scaler flags an error for non-BCD rise-delta; only a completed operation clears it.
// - Both scalers set the zero flag exactly when the result is zero.
// - Forward: (source minus offset) times rise-delta, divided by run-delta.
// - Both scalers round the quotient to the nearest integer.
// - Forward result saturates to the range minus 9999 to 9999.
// - Offset and slope may be positive, zero or negative; negative slope reverses.
// - Reverse source is a BCD magnitude signed by the carry flag.
// - Reverse scaler flags an error for a non-BCD source word.
// - Reverse scaler flags an error unless run-delta is BCD 0001 to 9999.
// - Reverse: (binary source plus offset) times rise-delta over binary run-delta.
// - Reverse result is clamped between the minimum and maximum words.
// - Reverse scaler sets the negative flag from the result's top bit.
`timescale 1ns/1ps
module slsu_scaler
  import slsu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // AHB-Lite slave request
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  // AHB-Lite slave answer
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic                   ap_valid;
  logic                   ap_write;
  logic [SLSU_ADDR_W-1:0] ap_addr;

  wire logic ap_take = hsel_in && hready_in && htrans_in[1];

  // Word size is the only size used; narrower writes still update the whole word.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else if (hready_in) begin
      ap_valid <= ap_take;
      ap_write <= hwrite_in;
      ap_addr  <= haddr_in[SLSU_ADDR_W-1:0];
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = SLSU_HRESP_OKAY;

  wire logic       wr_phase  = ap_valid && ap_write;
  wire logic       hit_ctrl  = ap_addr == SLSU_CTRL_OFS;
  wire logic       hit_src   = ap_addr == SLSU_SOURCE_OFS;
  wire logic       hit_param = (ap_addr >= SLSU_PARAM0_OFS) && (ap_addr <= SLSU_PARAM4_OFS)
                               && (ap_addr[1:0] == 2'b00);
  wire logic [2:0] param_idx = 3'((ap_addr - SLSU_PARAM0_OFS) >> 2);
  wire logic       wr_ctrl   = wr_phase && hit_ctrl;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0]  source_word;
  logic [15:0]  param_word [0:SLSU_PARAM_NUM-1];
  logic [15:0]  result_word;
  slsu_flags_s  flags;
  slsu_state_e  state;
  slsu_op_e     op;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_word <= SLSU_WORD_RESET;
      for (int i = 0; i < SLSU_PARAM_NUM; i++) begin
        param_word[i] <= SLSU_WORD_RESET;
      end
    end else if (wr_phase && hit_src) begin
      source_word <= hwdata_in[15:0];
    end else if (wr_phase && hit_param) begin
      param_word[param_idx] <= hwdata_in[15:0];
    end
  end

  wire logic [15:0] offset_word = param_word[SLSU_P_OFFSET];
  wire logic [15:0] run_word    = param_word[SLSU_P_RUN];
  wire logic [15:0] rise_word   = param_word[SLSU_P_RISE];
  wire logic [15:0] max_word    = param_word[SLSU_P_MAX];
  wire logic [15:0] min_word    = param_word[SLSU_P_MIN];

  wire logic busy = state != SLSU_IDLE;
  wire logic [15:0] status_word = {11'h000, flags, busy};

  // Reads decode the address held from the address phase, so a read that
  // directly follows a write already sees the written value.
  always_comb begin
    if (!ap_valid || ap_write) begin
      hrdata_out = 32'h00000000;
    end else if (hit_ctrl) begin
      hrdata_out = 32'h00000000;
    end else if (ap_addr == SLSU_STATUS_OFS) begin
      hrdata_out = {16'h0000, status_word};
    end else if (hit_src) begin
      hrdata_out = {16'h0000, source_word};
    end else if (hit_param) begin
      hrdata_out = {16'h0000, param_word[param_idx]};
    end else if (ap_addr == SLSU_RESULT_OFS) begin
      hrdata_out = {16'h0000, result_word};
    end else begin
      hrdata_out = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Operand checks
  // ----------------------------------------------------------------
  wire logic start_fwd = wr_ctrl && hwdata_in[SLSU_CTRL_FWD_BIT] && !busy;
  wire logic start_rev = wr_ctrl && hwdata_in[SLSU_CTRL_REV_BIT] && !hwdata_in[SLSU_CTRL_FWD_BIT]
                         && !busy;
  wire logic fwd_bad   = (run_word == 16'h0000)
                         || !slsu_bcd_valid(rise_word);
  wire logic rev_bad   = !slsu_bcd_valid(source_word)
                         || !slsu_bcd_valid(run_word) || (run_word == SLSU_BCD_ZERO);
  wire logic start_err = (start_fwd && fwd_bad) || (start_rev && rev_bad);
  wire logic start_div = (start_fwd && !fwd_bad) || (start_rev && !rev_bad);
  // A carry op still lands when the start in the same write is refused for bad operands.
  wire logic set_carry_op   = wr_ctrl && hwdata_in[SLSU_CTRL_SETC_BIT];
  wire logic clear_carry_op = wr_ctrl && hwdata_in[SLSU_CTRL_CLRC_BIT] && !set_carry_op;

  // ----------------------------------------------------------------
  // Numerator and divisor
  // ----------------------------------------------------------------
  // Forward: source, offset and run-delta are signed binary, rise-delta a BCD magnitude.
  wire logic signed [32:0] fwd_diff = 33'(signed'(source_word)) - 33'(signed'(offset_word));
  wire logic signed [32:0] fwd_rise = signed'({19'h00000, slsu_bcd_to_bin(rise_word)});
  wire logic signed [32:0] fwd_num  = fwd_diff * fwd_rise;
  wire logic signed [16:0] fwd_den  = 17'(signed'(run_word));

  // Reverse: source is a BCD magnitude signed by the carry flag.
  wire logic signed [32:0] rev_src  = signed'({19'h00000, slsu_bcd_to_bin(source_word)});
  wire logic signed [32:0] rev_sgn  = flags.carry ? -rev_src : rev_src;
  wire logic signed [32:0] rev_sum  = rev_sgn + 33'(signed'(offset_word));
  wire logic signed [32:0] rev_num  = rev_sum * 33'(signed'(rise_word));
  wire logic signed [16:0] rev_den  = signed'({3'b000, slsu_bcd_to_bin(run_word)});

  wire logic signed [32:0] num_sel  = start_rev ? rev_num : fwd_num;
  wire logic signed [16:0] den_sel  = start_rev ? rev_den : fwd_den;
  wire logic signed [32:0] num_abs  = num_sel[32] ? -num_sel : num_sel;
  wire logic signed [16:0] den_abs  = den_sel[16] ? -den_sel : den_sel;

  logic        res_neg;
  logic [15:0] den_mag;
  logic        div_done;
  logic [31:0] quot;
  logic [15:0] rem;

  slsu_divider #(
    .NUM_W (SLSU_DIV_NUM_W),
    .DEN_W (SLSU_DIV_DEN_W)
  ) u_divider (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .start_in (start_div),
    .numer_in (num_abs[31:0]),
    .denom_in (den_abs[15:0]),
    .busy_out (),
    .done_out (div_done),
    .quot_out (quot),
    .rem_out  (rem)
  );

  // ----------------------------------------------------------------
  // Rounding, saturation and clamping
  // ----------------------------------------------------------------
  // Halves round away from zero, since rounding acts on the magnitude.
  wire logic               round_up = {rem, 1'b0} >= {1'b0, den_mag};
  wire logic [32:0]        q_rnd    = {1'b0, quot} + {32'h00000000, round_up};
  wire logic signed [33:0] q_pos    = signed'({1'b0, q_rnd});
  wire logic signed [33:0] q_signed = res_neg ? -q_pos : q_pos;

  wire logic signed [33:0] fwd_sat  = (q_signed > SLSU_FWD_LIMIT) ? SLSU_FWD_LIMIT :
                                      (q_signed < -SLSU_FWD_LIMIT) ? -SLSU_FWD_LIMIT : q_signed;
  wire logic signed [33:0] fwd_mag  = fwd_sat[33] ? -fwd_sat : fwd_sat;
  wire logic [15:0]        fwd_bcd  = slsu_bin_to_bcd(fwd_mag[13:0]);

  wire logic signed [33:0] rev_min  = 34'(signed'(min_word));
  wire logic signed [33:0] rev_max  = 34'(signed'(max_word));
  wire logic signed [33:0] rev_clmp = (q_signed < rev_min) ? rev_min :
                                      (q_signed > rev_max) ? rev_max : q_signed;

  wire logic [15:0] next_result = (op == SLSU_OP_REV) ? rev_clmp[15:0] : fwd_bcd;

  // ----------------------------------------------------------------
  // Sequencing and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state   <= SLSU_IDLE;
      op      <= SLSU_OP_FWD;
      res_neg <= 1'b0;
      den_mag <= 16'h0000;
    end else begin
      case (state)
        SLSU_IDLE: begin
          if (start_div) begin
            state   <= SLSU_DIVIDE;
            op      <= start_rev ? SLSU_OP_REV : SLSU_OP_FWD;
            res_neg <= num_sel[32] ^ den_sel[16];
            den_mag <= den_abs[15:0];
          end
        end
        SLSU_DIVIDE: begin
          if (div_done) begin
            state <= SLSU_FINISH;
          end
        end
        SLSU_FINISH: begin
          state <= SLSU_IDLE;
        end
        default: begin
          state <= SLSU_IDLE;
        end
      endcase
    end
  end

  wire logic fin = state == SLSU_FINISH;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_word <= SLSU_WORD_RESET;
    end else if (fin) begin
      result_word <= next_result;  // Only completed operations reach here.
    end
  end

  // Completion beats a software carry op in the same cycle: forward completion writes
  // the carry from the sign of a fresh result, reverse completion keeps the old carry.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags <= '0;
    end else if (start_err) begin
      flags.error <= 1'b1;
      if (set_carry_op) begin
        flags.carry <= 1'b1;
      end else if (clear_carry_op) begin
        flags.carry <= 1'b0;
      end
    end else if (fin) begin
      flags.error <= 1'b0;
      if (op == SLSU_OP_FWD) begin
        flags.zero  <= fwd_sat == 34'sh0;
        flags.carry <= fwd_sat[33];
      end else begin
        flags.zero     <= rev_clmp[15:0] == 16'h0000;
        flags.negative <= rev_clmp[15];
      end
    end else if (set_carry_op) begin
      flags.carry <= 1'b1;
    end else if (clear_carry_op) begin
      flags.carry <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_err_run_zero: assert property (start_fwd && run_word == 16'h0000 |=> flags.error && !busy)
    else $error("forward run-delta of zero did not raise the error flag");

  a_err_rise_bcd: assert property (start_fwd && !slsu_bcd_valid(rise_word) |=> flags.error)
    else $error("forward non-BCD rise-delta did not raise the error flag");

  a_err_src_bcd: assert property (start_rev && !slsu_bcd_valid(source_word) |=> flags.error)
    else $error("reverse non-BCD source did not raise the error flag");

  a_err_run_range: assert property (start_rev && run_word == 16'h0000 |=> flags.error)
    else $error("reverse run-delta outside range did not raise the error flag");

  a_result_kept: assert property (start_err |=> $stable(result_word) && state == SLSU_IDLE)
    else $error("result changed after an erroneous operation");

  a_done_bound: assert property (start_div |-> ##[33:36] fin ##1 (!flags.error && !busy))
    else $error("operation did not complete in the expected number of cycles");

  a_zero_flag: assert property (fin |=> flags.zero == (result_word == 16'h0000))
    else $error("zero flag disagrees with the result");

  a_carry_sign: assert property (fin && op == SLSU_OP_FWD |=> !(flags.carry && result_word == 16'h0000))
    else $error("carry flag set for a zero forward result");

  a_fwd_sat: assert property (fin && op == SLSU_OP_FWD |=> result_word <= 16'h9999
                              && slsu_bcd_valid(result_word))
    else $error("forward result is not a BCD value within 9999");

  a_rev_clamp: assert property (fin && op == SLSU_OP_REV && $signed(min_word) <= $signed(max_word)
                                |=> $signed(result_word) >= $signed(min_word)
                                && $signed(result_word) <= $signed(max_word))
    else $error("reverse result outside the programmed limits");

  a_neg_msb: assert property (fin && op == SLSU_OP_REV |=> flags.negative == result_word[15])
    else $error("negative flag disagrees with the result top bit");

  a_err_run_bcd: assert property (start_rev && !slsu_bcd_valid(run_word) |=> flags.error)
    else $error("reverse non-BCD run-delta did not raise the error flag");

  a_carry_set: assert property (set_carry_op && !fin |=> flags.carry)
    else $error("set carry op did not set the carry flag");

  a_carry_clear: assert property (clear_carry_op && !fin |=> !flags.carry)
    else $error("clear carry op did not clear the carry flag");

  a_rev_carry_kept: assert property (fin && op == SLSU_OP_REV |=> $stable(flags.carry))
    else $error("reverse completion changed the carry flag");

  a_fwd_neg_kept: assert property (fin && op == SLSU_OP_FWD |=> $stable(flags.negative))
    else $error("forward completion changed the negative flag");

  a_err_flags_kept: assert property (start_err |=> $stable(flags.zero) && $stable(flags.negative))
    else $error("erroneous operation changed the zero or negative flag");

endmodule // slsu_scaler

// ==== verification/signed_linear_scaling_unit_tb.sv ====
/*
  Self-checking testbench for the signed linear scaling unit.
  Assumes the sequencer model as the only bus master.
*/
`timescale 1ns/1ps
module signed_linear_scaling_unit_tb
  import slsu_pkg::*;
;
  // ----------------------------------------------------------------
  // Rows: mode (bit1 reverse, bit0 carry), source, five words, result, flags
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]   mode;
    logic [15:0]  src;
    logic [79:0]  prm;
    logic [15:0]  res;
    logic [3:0]   flg;
  } slsu_row_s;
  localparam int NROW = 16;
  slsu_row_s rows [NROW] = '{
    120'h0_0064_0000_0003_0002_0000_0000_0067_0, 120'h0_0000_000a_0004_0001_0000_0000_0003_1,
    120'h0_7fff_0000_0001_0001_0000_0000_9999_0, 120'h0_8001_0000_0001_0001_0000_0000_9999_1,
    120'h0_000a_0000_fffe_0003_0000_0000_0015_1, 120'h0_0064_0000_0000_0001_0000_0000_0015_4,
    120'h0_0064_0000_0001_00a0_0000_0000_0015_4, 120'h0_0005_0005_0001_0001_0000_0000_0000_2,
    120'h2_0200_0000_0200_1770_7fff_8000_1770_0, 120'h3_0005_0000_0002_0003_7fff_8000_fff8_1,
    120'h2_0100_0000_0001_0001_0032_8000_0032_0, 120'h2_0003_fffd_0001_0005_7fff_8000_0000_2,
    120'h3_0100_0000_0001_0001_7fff_ffce_ffce_1, 120'h2_00a0_0000_0001_0001_7fff_8000_ffce_4,
    120'h2_0003_0000_0000_0001_7fff_8000_ffce_4, 120'h2_0003_0000_a000_0001_7fff_8000_ffce_4};

  logic        clk_in;
  logic        reset_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [31:0] d;
  slsu_row_s   r;
  int          num_errors = 0;
  int          comparisons = 0;

  slsu_scaler i_dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));
  slsu_seq_model i_seq (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Polls busy with a bound, since the divider length is not a documented figure.
  task automatic wait_idle(output logic [31:0] st);
    for (int n = 0; n < 80; n++) begin
      i_seq.xfer(1'b0, SLSU_STATUS_OFS, 16'h0000, st);
      if (st[0] === 1'b0) return;
    end
    check("busy", {31'h0, st[0]}, 32'h0);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end

  initial begin
    reset_in = 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < NROW; i++) begin
      r = rows[i];
      i_seq.load(r.src, r.prm);
      if (r.mode[1]) i_seq.set_sign(r.mode[0]);
      i_seq.xfer(1'b1, SLSU_CTRL_OFS, r.mode[1] ? 16'h0002 : 16'h0001, d);
      wait_idle(d);
      if (r.flg[2]) check("error", {31'h0, d[1]}, 32'h1);
      else check("flags", 32'({d[1], d[2], r.mode[1] ? d[4] : d[3]}), 32'(r.flg[2:0]));
      i_seq.xfer(1'b0, SLSU_RESULT_OFS, 16'h0000, d);
      check("result", d, 32'(r.res));
    end
    i_seq.xfer(1'b1, SLSU_RESULT_OFS, 16'h1234, d);
    i_seq.xfer(1'b0, SLSU_RESULT_OFS, 16'h0000, d);
    check("result read-only", d, 32'h0000ffce);
    i_seq.xfer(1'b0, 8'h40, 16'h0000, d);
    check("unmapped", d, 32'h0);
    i_seq.xfer(1'b0, SLSU_CTRL_OFS, 16'h0000, d);
    check("ctrl reads zero", d, 32'h0);
    i_seq.xfer(1'b1, SLSU_CTRL_OFS, 16'h0001, d);
    i_seq.xfer(1'b0, SLSU_STATUS_OFS, 16'h0000, d);
    check("busy after start", {31'h0, d[0]}, 32'h1);
    i_seq.xfer(1'b1, SLSU_CTRL_OFS, 16'h0002, d);
    wait_idle(d);
    check("start while busy dropped", d, 32'h00000014);
    i_seq.xfer(1'b1, SLSU_CTRL_OFS, 16'h0001, d);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    i_seq.xfer(1'b0, SLSU_STATUS_OFS, 16'h0000, d);
    check("status after reset", d, 32'h0);
    i_seq.xfer(1'b0, SLSU_RESULT_OFS, 16'h0000, d);
    check("result after reset", d, 32'h0);
    i_seq.load(16'h0010, 80'h0000_0001_0001_7fff_8000);
    i_seq.xfer(1'b1, SLSU_CTRL_OFS, 16'h000c, d);
    i_seq.xfer(1'b0, SLSU_STATUS_OFS, 16'h0000, d);
    check("set beats clear", d, 32'h00000008);
    i_seq.xfer(1'b1, SLSU_CTRL_OFS, 16'h0003, d);
    wait_idle(d);
    check("forward wins flags", d, 32'h0);
    i_seq.xfer(1'b0, SLSU_RESULT_OFS, 16'h0000, d);
    check("forward wins result", d, 32'h00000016);
    check("hready", {31'h0, hready}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
    wrap_up();
  end
endmodule // signed_linear_scaling_unit_tb

// ==== verification/slsu_seq_model.sv ====
/*
  Bus-master model of the instruction sequencer that feeds the scaling unit.
  Assumes a single AHB-Lite slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module slsu_seq_model
  import slsu_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Bus answer
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  // Bus request
  output logic             hsel_out,
  output logic [31:0]      haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  // ----------------------------------------------------------------
  // Single-word transfers
  // ----------------------------------------------------------------
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h00000000;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out  = 3'b010;
    hwdata_out = 32'h00000000;
  end

  // Released address and write-data lines are inverted so a stale value can never look valid; hsel and htrans go idle.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_out   <= 1'b1;
    haddr_out  <= {24'h000000, a};
    htrans_out <= 2'b10;
    hwrite_out <= wr;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_out   <= 1'b0;
    htrans_out <= 2'b00;
    haddr_out  <= ~{24'h000000, a};
    hwdata_out <= {16'h0000, wd};
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
    hwdata_out <= ~{16'h0000, wd};
  endtask

  // Source first, then the parameter words back to back from the base.
  task automatic load(input logic [15:0] src, input logic [79:0] p);
    logic [31:0] d;
    xfer(1'b1, SLSU_SOURCE_OFS, src, d);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, SLSU_PARAM0_OFS + 8'(4 * k), p[79-16*k -: 16], d);
    end
  endtask

  task automatic set_sign(input logic cy);
    logic [31:0] d;
    xfer(1'b1, SLSU_CTRL_OFS, cy ? 16'h0004 : 16'h0008, d);
  endtask
endmodule // slsu_seq_model
